/* File: design/sgp_pkg.sv */
// package: register map, field layout and mode codes for the pin configuration block
package sgp_pkg;
   // register byte addresses
   localparam logic [7:0] OFS_PINS_ONE_TWO = 8'h0e;
   localparam logic [7:0] OFS_PIN_THREE = 8'h0f;
   localparam logic [7:0] OFS_PINS_FIVE_SIX = 8'h10;
   localparam logic [7:0] OFS_PORT_CTRL = 8'h20;
   localparam logic [7:0] OFS_PIN_STATUS = 8'h24;
   // reset values
   localparam logic [7:0] RST_PINS_ONE_TWO = 8'h00;
   localparam logic [7:0] RST_PIN_THREE = 8'h00;
   localparam logic [7:0] RST_PINS_FIVE_SIX = 8'h00;
   localparam logic RST_PORT_SEL = 1'b0;
   // field positions
   localparam int POS_ONE_MODE = 0;
   localparam int POS_ONE_VAL = 3;
   localparam int POS_TWO_MODE = 4;
   localparam int POS_TWO_VAL = 7;
   localparam int POS_THREE_MODE = 0;
   localparam int POS_THREE_VAL = 3;
   localparam int POS_FIVE_MODE = 0;
   localparam int POS_FIVE_VAL = 3;
   localparam int POS_SIX_MODE = 4;
   localparam int POS_SIX_VAL = 7;
   localparam int POS_PORT_SEL = 0;
   localparam logic [7:0] MASK_PIN_THREE = 8'h0f;
   localparam logic [7:0] MASK_FIVE_SIX = 8'hbb;
   // mode codes
   localparam logic [1:0] LOW_FUNC_IN = 2'h0;
   localparam logic [1:0] LOW_HIGH_Z = 2'h2;
   localparam logic [2:0] MODE_GP_OUT = 3'h1;
   localparam logic [2:0] MODE_GP_IN = 3'h3;
   localparam logic [2:0] MODE_REMOTE_HOLD = 3'h5;
   localparam logic [2:0] MODE_REMOTE_DEFAULT = 3'h7;
   localparam logic [1:0] SMODE_GP_OUT = 2'h1;
   // bus answer state
   typedef enum logic [0:0] {BUS_IDLE, BUS_ACKED} sgp_bus_t;
endpackage

/* File: design/sgp_pin_ctl.sv */
// one pin: mode decode, remote value capture and output drive
`timescale 1ns/1ps
module sgp_pin_ctl
   import sgp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire logic [2:0] mode,
   input wire logic out_val,
   // remote side
   input wire logic link_up,
   input wire logic remote_valid,
   input wire logic remote_val,
   // pin
   output logic pin_o,
   output logic pin_oe,
   output logic func_in
);
   logic remote_q;
   logic remote_mode;
   logic next_o;
   logic next_oe;

   assign remote_mode = (mode == MODE_REMOTE_HOLD) || (mode == MODE_REMOTE_DEFAULT);

   // capture of remote value, held otherwise
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         remote_q <= 1'b0;
      else if (remote_mode && link_up && remote_valid)
         remote_q <= remote_val;
   end

   always_comb
   begin
      next_o = 1'b0;
      next_oe = 1'b0;
      func_in = (mode[1:0] == LOW_FUNC_IN);
      case (mode)
         MODE_GP_OUT:
         begin
            next_oe = 1'b1;
            next_o = out_val;
         end
         MODE_REMOTE_HOLD:
         begin
            next_oe = 1'b1;
            next_o = (link_up && remote_valid) ? remote_val : remote_q;
         end
         MODE_REMOTE_DEFAULT:
         begin
            next_oe = 1'b1;
            if (!link_up)
               next_o = out_val;
            else
               next_o = remote_valid ? remote_val : remote_q;
         end
         default:
         begin
            next_oe = 1'b0; // inputs, high impedance, functional
            next_o = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
      end
      else
      begin
         pin_o <= next_o;
         pin_oe <= next_oe;
      end
   end

   a_local_out_drive: assert property (@(posedge clk) disable iff (!rst_n)
      mode == MODE_GP_OUT |=> pin_oe && pin_o == $past(out_val))
      else $error("local output not driven");
   a_highz_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
      mode[1:0] == LOW_HIGH_Z |=> !pin_oe)
      else $error("high impedance pin driven");
   a_input_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
      mode == MODE_GP_IN |-> !func_in ##1 !pin_oe)
      else $error("input pin driven");
   a_hold_on_loss: assert property (@(posedge clk) disable iff (!rst_n)
      $past(mode) == MODE_REMOTE_HOLD && mode == MODE_REMOTE_HOLD && !link_up
      |=> pin_o == $past(pin_o))
      else $error("remote hold lost value");
   a_default_on_loss: assert property (@(posedge clk) disable iff (!rst_n)
      mode == MODE_REMOTE_DEFAULT && !link_up |=> pin_oe && pin_o == $past(out_val))
      else $error("remote default not driven");
   a_remote_update: assert property (@(posedge clk) disable iff (!rst_n)
      remote_mode && link_up && remote_valid |=> pin_o == $past(remote_val))
      else $error("remote value not taken");
   c_remote_loss: cover property (@(posedge clk) disable iff (!rst_n)
      remote_mode && link_up ##1 remote_mode && !link_up);
endmodule

/* File: design/sgp_wb_slave.sv */
// classic wishbone slave handshake: one-cycle answer, ack drops after
`timescale 1ns/1ps
module sgp_wb_slave
   import sgp_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus
   input wire logic cyc,
   input wire logic stb,
   input wire logic we,
   // answer
   output logic ack,
   output logic wr_go
);
   sgp_bus_t state;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= BUS_IDLE;
      else
      begin
         case (state)
            BUS_IDLE:
               if (cyc && stb)
                  state <= BUS_ACKED;
            BUS_ACKED:
               state <= BUS_IDLE;
            default:
               state <= BUS_IDLE;
         endcase
      end
   end

   assign ack = (state == BUS_ACKED) && cyc && stb;
   assign wr_go = ack && we;

   a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
      ack |=> !ack)
      else $error("ack held two cycles");
   c_bus_write: cover property (@(posedge clk) disable iff (!rst_n) wr_go);
endmodule

/* File: design/sgp_pin_config.sv */
// top: pin configuration registers, port select and per-pin drive
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps

module sgp_pin_config
   import sgp_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // link status and back channel, one per port
   input wire logic [1:0] LINK_UP,
   input wire logic [1:0] REMOTE_VALID,
   input wire logic [5:0] REMOTE_VAL,
   // first port pins one to three
   output logic [2:0] GENERAL_PIN_O,
   output logic [2:0] GENERAL_PIN_OE,
   output logic [2:0] GENERAL_PIN_FUNC,
   // second port pins one to three
   output logic [2:0] SECOND_PORT_PIN_O,
   output logic [2:0] SECOND_PORT_PIN_OE,
   output logic [2:0] SECOND_PORT_PIN_FUNC,
   // register pins five and six
   output logic [1:0] REGISTER_PIN_O,
   output logic [1:0] REGISTER_PIN_OE
);
   // =========================================================
   // registers
   logic wr_go;
   logic [7:0] pins_one_two_config[2];
   logic [7:0] pin_three_config[2];
   logic [7:0] pins_five_six_config;
   logic second_port_select;
   logic [7:0] wdat;
   logic sel_idx;
   logic [31:0] next_dat;

   sgp_wb_slave u_bus (
      .clk(CLK),
      .rst_n(RST_N),
      .cyc(CYC_I),
      .stb(STB_I),
      .we(WE_I),
      .ack(ACK_O),
      .wr_go(wr_go)
   );

   assign wdat = DAT_I[7:0];
   assign sel_idx = second_port_select;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         second_port_select <= RST_PORT_SEL;
      else if (wr_go && SEL_I[0] && ADR_I == OFS_PORT_CTRL)
         second_port_select <= wdat[POS_PORT_SEL];
   end

   // one register bank per port, chosen by the port select
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pins_one_two_config[0] <= RST_PINS_ONE_TWO;
         pins_one_two_config[1] <= RST_PINS_ONE_TWO;
         pin_three_config[0] <= RST_PIN_THREE;
         pin_three_config[1] <= RST_PIN_THREE;
      end
      else if (wr_go && SEL_I[0])
      begin
         if (ADR_I == OFS_PINS_ONE_TWO)
            pins_one_two_config[sel_idx] <= wdat;
         if (ADR_I == OFS_PIN_THREE)
            pin_three_config[sel_idx] <= wdat & MASK_PIN_THREE;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         pins_five_six_config <= RST_PINS_FIVE_SIX;
      else if (wr_go && SEL_I[0] && ADR_I == OFS_PINS_FIVE_SIX)
         pins_five_six_config <= wdat & MASK_FIVE_SIX;
   end

   // =========================================================
   // read data
   always_comb
   begin
      next_dat = 32'h0000_0000;
      case (ADR_I)
         OFS_PINS_ONE_TWO: next_dat[7:0] = pins_one_two_config[sel_idx];
         OFS_PIN_THREE: next_dat[7:0] = pin_three_config[sel_idx];
         OFS_PINS_FIVE_SIX: next_dat[7:0] = pins_five_six_config;
         OFS_PORT_CTRL: next_dat[0] = second_port_select;
         OFS_PIN_STATUS:
         begin
            next_dat[2:0] = sel_idx ? SECOND_PORT_PIN_O : GENERAL_PIN_O;
            next_dat[5:3] = sel_idx ? SECOND_PORT_PIN_OE : GENERAL_PIN_OE;
            next_dat[7:6] = REGISTER_PIN_O;
         end
         default: next_dat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         DAT_O <= 32'h0000_0000;
      else if (CYC_I && STB_I && !ACK_O)
         DAT_O <= next_dat;
   end

   // =========================================================
   // pins of both ports
   logic [2:0] pin_o[2];
   logic [2:0] pin_oe[2];
   logic [2:0] pin_func[2];

   genvar p;
   genvar n;
   generate
      for (p = 0; p < 2; p++)
      begin : g_port
         for (n = 0; n < 3; n++)
         begin : g_pin
            logic [2:0] mode;
            logic val;
            if (n == 0)
            begin : g_one
               assign mode = pins_one_two_config[p][POS_ONE_MODE +: 3];
               assign val = pins_one_two_config[p][POS_ONE_VAL];
            end
            else if (n == 1)
            begin : g_two
               assign mode = pins_one_two_config[p][POS_TWO_MODE +: 3];
               assign val = pins_one_two_config[p][POS_TWO_VAL];
            end
            else
            begin : g_three
               assign mode = pin_three_config[p][POS_THREE_MODE +: 3];
               assign val = pin_three_config[p][POS_THREE_VAL];
            end
            sgp_pin_ctl u_pin (
               .clk(CLK),
               .rst_n(RST_N),
               .mode(mode),
               .out_val(val),
               .link_up(LINK_UP[p]),
               .remote_valid(REMOTE_VALID[p]),
               .remote_val(REMOTE_VAL[p*3+n]),
               .pin_o(pin_o[p][n]),
               .pin_oe(pin_oe[p][n]),
               .func_in(pin_func[p][n])
            );
         end
      end
   endgenerate

   assign GENERAL_PIN_O = pin_o[0];
   assign GENERAL_PIN_OE = pin_oe[0];
   assign GENERAL_PIN_FUNC = pin_func[0];
   assign SECOND_PORT_PIN_O = pin_o[1];
   assign SECOND_PORT_PIN_OE = pin_oe[1];
   assign SECOND_PORT_PIN_FUNC = pin_func[1];

   // =========================================================
   // pins five and six: two-bit modes, local only
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         REGISTER_PIN_O <= 2'h0;
         REGISTER_PIN_OE <= 2'h0;
      end
      else
      begin
         REGISTER_PIN_OE[0] <= pins_five_six_config[POS_FIVE_MODE +: 2] == SMODE_GP_OUT;
         REGISTER_PIN_O[0] <= (pins_five_six_config[POS_FIVE_MODE +: 2] == SMODE_GP_OUT)
                              && pins_five_six_config[POS_FIVE_VAL];
         REGISTER_PIN_OE[1] <= pins_five_six_config[POS_SIX_MODE +: 2] == SMODE_GP_OUT;
         REGISTER_PIN_O[1] <= (pins_five_six_config[POS_SIX_MODE +: 2] == SMODE_GP_OUT)
                              && pins_five_six_config[POS_SIX_VAL];
      end
   end

   // =========================================================
   // checks
   a_pin_six_drive: assert property (@(posedge CLK) disable iff (!RST_N)
      pins_five_six_config[POS_SIX_MODE +: 2] == SMODE_GP_OUT
      |=> REGISTER_PIN_OE[1] && REGISTER_PIN_O[1] == $past(pins_five_six_config[POS_SIX_VAL]))
      else $error("pin six not driven");
   a_port_steer: assert property (@(posedge CLK) disable iff (!RST_N)
      wr_go && SEL_I[0] && ADR_I == OFS_PINS_ONE_TWO && second_port_select
      |=> pins_one_two_config[1] == $past(wdat)
          && pins_one_two_config[0] == $past(pins_one_two_config[0]))
      else $error("port select not honoured");
   a_three_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
      ACK_O && !WE_I && ADR_I == OFS_PIN_THREE |-> DAT_O[7:4] == 4'h0)
      else $error("reserved bits nonzero");
   a_one_two_layout: assert property (@(posedge CLK) disable iff (!RST_N)
      pins_one_two_config[0][POS_TWO_MODE +: 3] == MODE_GP_OUT
      ##1 pins_one_two_config[0][POS_TWO_MODE +: 3] == MODE_GP_OUT
      |=> GENERAL_PIN_OE[1] && GENERAL_PIN_O[1] == $past(pins_one_two_config[0][POS_TWO_VAL], 1))
      else $error("pin two layout wrong");
   c_second_port: cover property (@(posedge CLK) disable iff (!RST_N) |SECOND_PORT_PIN_OE);
   c_read: cover property (@(posedge CLK) disable iff (!RST_N) ACK_O && !WE_I);
endmodule

/* File: verif/sgp_remote_des.sv */
// remote deserializer model: link status and back channel pin values
`timescale 1ns/1ps
module sgp_remote_des
(
   // clock
   input wire logic clk,
   // back channel
   output logic [1:0] link_up,
   output logic [1:0] valid,
   output logic [5:0] val
);
   logic [5:0] held;
   logic [5:0] junk;
   initial
   begin
      link_up = 2'h3;
      valid = 2'h0;
      held = 6'h00;
      junk = 6'h2a;
   end
   // lines outside a frame never hold a stale value
   always @(posedge clk)
      junk <= ~junk;
   assign val = {valid[1] ? held[5:3] : junk[5:3], valid[0] ? held[2:0] : junk[2:0]};
   // one-cycle frame after gap + 1 idle cycles
   task automatic send(input int p, input logic [2:0] b, input int gap);
      repeat (gap + 1) @(posedge clk);
      held[p*3+:3] <= b;
      valid[p] <= 1'b1;
      @(posedge clk);
      valid[p] <= 1'b0;
   endtask
   task automatic set_link(input int p, input logic l);
      @(posedge clk);
      link_up[p] <= l;
   endtask
endmodule

/* File: verif/test_sgp_pin_config.sv */
// testbench: register access, pin modes, port select, link loss
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module test_sgp_pin_config;
   import sgp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h1;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack;
   logic [1:0] link, rv, r_o, r_oe;
   logic [5:0] rval;
   logic [2:0] g_o, g_oe, g_fn, s_o, s_oe, s_fn;
   int err_total = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [31:0] rnd = 32'h08c1ca6a;
   logic [2:0] md [2][3] = '{default: 3'h0};
   logic vl [2][3] = '{default: 1'b0};
   logic [2:0] cap [2] = '{default: 3'h0};
   always #10 clk = ~clk;
   sgp_pin_config dut (.CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .LINK_UP(link),
      .REMOTE_VALID(rv), .REMOTE_VAL(rval), .GENERAL_PIN_O(g_o), .GENERAL_PIN_OE(g_oe),
      .GENERAL_PIN_FUNC(g_fn), .SECOND_PORT_PIN_O(s_o), .SECOND_PORT_PIN_OE(s_oe),
      .SECOND_PORT_PIN_FUNC(s_fn), .REGISTER_PIN_O(r_o), .REGISTER_PIN_OE(r_oe));
   sgp_remote_des far (.clk(clk), .link_up(link), .valid(rv), .val(rval));
   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // {functional, driven, driven value}
   function automatic logic [2:0] exp_pin(input logic [2:0] m, input logic v, input logic lk,
      input logic c);
      logic oe;
      logic o;
      oe = (m == MODE_GP_OUT) || (m == MODE_REMOTE_HOLD) || (m == MODE_REMOTE_DEFAULT);
      o = (m == MODE_GP_OUT || (m == MODE_REMOTE_DEFAULT && !lk)) ? v : c;
      return {m[1:0] == LOW_FUNC_IN, oe, oe & o};
   endfunction
   task automatic tally_and_finish;
      if (err_total == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat_i <= {24'h0, d};
      // ack sampled at the rising edge; request held until then
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         err_total++;
         $display("MISMATCH t=%0t bus timeout", $time);
         tally_and_finish();
      end
      else
      begin
         q = dat_o[7:0];
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(a, 1'b1, 4'h1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      wb(a, 1'b0, 4'h1, 8'h00, q);
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic cfg(input int p);
      wr(OFS_PINS_ONE_TWO, {vl[p][1], md[p][1], vl[p][0], md[p][0]});
      wr(OFS_PIN_THREE, {rnd[7:4], vl[p][2], md[p][2]});
   endtask
   task automatic chk_port(input int p);
      logic [2:0] e;
      for (int n = 0; n < 3; n++)
      begin
         e = exp_pin(md[p][n], vl[p][n], link[p], cap[p][n]);
         if (p == 0)
            `CHK({g_fn[n], g_oe[n], g_oe[n] & g_o[n]}, e)
         else
            `CHK({s_fn[n], s_oe[n], s_oe[n] & s_o[n]}, e)
      end
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         $display("MISMATCH t=%0t run timeout", $time);
         tally_and_finish();
      end
   end
   // ==========================================
   // main sequence
   initial
   begin
      logic [7:0] q;
      logic [7:0] d;
      logic [1:0] e;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      settle;
      `CHK({g_fn, s_fn, g_oe, s_oe, r_oe}, 14'h3f00)
      rd(OFS_PINS_ONE_TWO, q);
      `CHK(q, RST_PINS_ONE_TWO)
      rd(OFS_PINS_FIVE_SIX, q);
      `CHK(q, RST_PINS_FIVE_SIX)
      wr(OFS_PIN_THREE, 8'hff);
      wb(OFS_PIN_THREE, 1'b1, 4'h0, 8'h00, q);
      rd(OFS_PIN_THREE, q);
      `CHK(q, MASK_PIN_THREE)
      wr(8'h33, 8'hff);
      rd(8'h33, q);
      `CHK(q, 8'h00)
      // every mode code on both ports, remote frames slow and prompt
      for (int p = 0; p < 2; p++)
      begin
         wr(OFS_PORT_CTRL, {7'h0, p[0]});
         rd(OFS_PORT_CTRL, q);
         `CHK(q, {7'h0, p[0]})
         for (int k = 0; k < 16; k++)
         begin
            rnd = lfsr(rnd);
            md[p] = '{k[2:0], rnd[2:0], rnd[5:3]};
            vl[p] = '{rnd[8], rnd[9], rnd[10]};
            cfg(p);
            rd(OFS_PINS_ONE_TWO, q);
            `CHK(q, {vl[p][1], md[p][1], vl[p][0], md[p][0]})
            rnd = lfsr(rnd);
            far.send(p, rnd[2:0], k % 3);
            cap[p] = rnd[2:0];
            settle;
            chk_port(0);
            chk_port(1);
         end
      end
      // link loss: hold versus local value
      wr(OFS_PORT_CTRL, 8'h00);
      md[0] = '{MODE_REMOTE_HOLD, MODE_REMOTE_DEFAULT, MODE_REMOTE_DEFAULT};
      vl[0] = '{1'b0, 1'b1, 1'b1};
      cfg(0);
      far.send(0, 3'b001, 0);
      cap[0] = 3'b001;
      far.set_link(0, 1'b0);
      far.send(0, 3'b110, 1);
      settle;
      chk_port(0);
      vl[0][1] = 1'b0;
      cfg(0);
      settle;
      chk_port(0);
      far.set_link(0, 1'b1);
      far.send(0, 3'b110, 2);
      cap[0] = 3'b110;
      settle;
      chk_port(0);
      // pins five and six
      for (int k = 0; k < 4; k++)
      begin
         rnd = lfsr(rnd);
         d = k < 2 ? (k == 1 ? 8'h19 : 8'h91) : rnd[7:0];
         e = {d[5:4] == SMODE_GP_OUT, d[1:0] == SMODE_GP_OUT};
         wr(OFS_PINS_FIVE_SIX, d);
         settle;
         rd(OFS_PINS_FIVE_SIX, q);
         `CHK(q, d & MASK_FIVE_SIX)
         `CHK(r_oe, e)
         `CHK(r_o & e, {d[7], d[3]} & e)
      end
      tally_and_finish();
   end
endmodule
